/* File: hdl/ebt_cfg.svh */
// ebt_cfg.svh: constants of the external bus transfer engine
// assumes: included by the package and design files by bare name
`ifndef EBT_CFG_SVH
`define EBT_CFG_SVH

// size output encodings (bytes still to move)
`define EBT_SIZE_BYTE    2'h1
`define EBT_SIZE_WORD    2'h2
`define EBT_SIZE_THREE   2'h3
`define EBT_SIZE_LONG    2'h0

// acknowledge pair (active low) port-size answers
`define EBT_ACK_PORT8    2'h2
`define EBT_ACK_PORT16   2'h1
`define EBT_ACK_PORT16B  2'h0

// cycle lengths in clocks
`define EBT_SYNC_CLKS    3
`define EBT_FAST_CLKS    2

// synchroniser depth for asynchronous mode
`define EBT_SYNC_DEPTH   2

`endif

/* File: hdl/ebt_pkg.sv */
// ebt_pkg.sv: types of the external bus transfer engine
// assumes: ebt_cfg.svh on the include path
package ebt_pkg;
`include "ebt_cfg.svh"

   // operand length requested by the core
   typedef enum logic [1:0] {
      EBT_OP_BYTE = 2'b00,
      EBT_OP_WORD = 2'b01,
      EBT_OP_LONG = 2'b10
   } ebt_op_t;

   // cycle style
   typedef enum logic [1:0] {
      EBT_MODE_ASYNC = 2'b00,
      EBT_MODE_SYNC  = 2'b01,
      EBT_MODE_FAST  = 2'b10
   } ebt_mode_t;

   // bus state machine
   typedef enum logic [2:0] {
      EBT_IDLE  = 3'b000,
      EBT_ADDR  = 3'b001,
      EBT_WAIT  = 3'b010,
      EBT_DONE  = 3'b011,
      EBT_ERROR = 3'b100
   } ebt_state_t;

   // byte count to size code
   function automatic logic [1:0] ebt_size_code(input logic [2:0] left);
      case (left)
         3'd1:    ebt_size_code = `EBT_SIZE_BYTE;
         3'd2:    ebt_size_code = `EBT_SIZE_WORD;
         3'd3:    ebt_size_code = `EBT_SIZE_THREE;
         default: ebt_size_code = `EBT_SIZE_LONG;
      endcase
   endfunction : ebt_size_code

endpackage : ebt_pkg

/* File: hdl/ebt_in_if.sv */
// ebt_in_if.sv: resolved bus inputs passed from sampler to engine
// assumes: one clock, driven by ebt_in_sampler only
`timescale 1ns/1ps
interface ebt_in_if;
   logic       ackHiN;    // resolved high acknowledge, active low
   logic       ackLoN;    // resolved low acknowledge, active low
   logic       faultN;    // resolved bus fault, active low
   logic [15:0] rdData;   // captured read data
   modport sampler (output ackHiN, ackLoN, faultN, rdData);
   modport engine  (input  ackHiN, ackLoN, faultN, rdData);
endinterface : ebt_in_if

/* File: hdl/ebt_in_sampler.sv */
// ebt_in_sampler.sv: input capture, direct or synchronised
// assumes: pins sampled on core_clk; async mode adds stages
`timescale 1ns/1ps
`include "ebt_cfg.svh"
module ebt_in_sampler
   import ebt_pkg::*;
#(
   parameter int DEPTH = `EBT_SYNC_DEPTH
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // mode
   input  wire logic        syncBypass,
   // pins
   input  wire logic        sizeAckHiN,
   input  wire logic        sizeAckLoN,
   input  wire logic        busFaultInN,
   input  wire logic [15:0] dataIn,
   // resolved
   ebt_in_if.sampler        res
);
   // refuse a chain too short to hold a synchroniser
   if (DEPTH < 2) begin : gBadDepth
      $error("sampler depth must be at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0] hi;
      logic [DEPTH-1:0] lo;
      logic [DEPTH-1:0] ft;
      logic [15:0]      dat;
   } ebt_smp_t;

   ebt_smp_t stReg;
   ebt_smp_t stNext;

   always_comb begin
      stNext     = stReg;
      stNext.hi  = {stReg.hi[DEPTH-2:0], sizeAckHiN};
      stNext.lo  = {stReg.lo[DEPTH-2:0], sizeAckLoN};
      stNext.ft  = {stReg.ft[DEPTH-2:0], busFaultInN};
      stNext.dat = dataIn;
   end

   // every input taken at one clock edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stReg <= '{hi: '1, lo: '1, ft: '1, dat: 16'h0000};
      end else begin
         stReg <= stNext;
      end
   end

   assign res.ackHiN = syncBypass ? stReg.hi[0] : stReg.hi[DEPTH-1];
   assign res.ackLoN = syncBypass ? stReg.lo[0] : stReg.lo[DEPTH-1];
   assign res.faultN = syncBypass ? stReg.ft[0] : stReg.ft[DEPTH-1];
   assign res.rdData = stReg.dat;
endmodule : ebt_in_sampler

/* File: hdl/ebt_byte_lane.sv */
// ebt_byte_lane.sv: operand assembly store for read bytes
// assumes: one write per cycle; read data from register
`timescale 1ns/1ps
module ebt_byte_lane
   import ebt_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // write side
   input  wire logic        clear,
   input  wire logic        wrEn,
   input  wire logic [1:0]  wrIdx,
   input  wire logic        wrTwo,
   input  wire logic [15:0] wrData,
   // read side
   output logic      [31:0] rdWord
);
   typedef struct packed {
      logic [3:0][7:0] mem;
   } ebt_lane_t;

   ebt_lane_t stReg;
   ebt_lane_t stNext;

   // place bytes, byte index 0 is most significant
   always_comb begin
      stNext = stReg;
      if (clear) begin
         stNext.mem = '0;
      end else if (wrEn) begin
         if (wrTwo) begin
            stNext.mem[2'd3 - wrIdx]        = wrData[15:8];
            stNext.mem[2'd3 - wrIdx - 2'd1] = wrData[7:0];
         end else begin
            stNext.mem[2'd3 - wrIdx] = wrData[15:8];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stReg <= '{mem: '0};
      end else begin
         stReg <= stNext;
      end
   end

   assign rdWord = stReg.mem;
endmodule : ebt_byte_lane

/* File: hdl/ebt_bus_master.sv */
// ebt_bus_master.sv: external bus transfer engine, device side
// assumes: core issues one operand at a time; pins are synchronous
// to core_clk; rising edge stands for the documented falling edge
//
// Contract
// - word and long operands go only to even addresses
// - odd addresses carry single-byte transfers only
// - narrow port splits operands into successive bus cycles
// - slave acknowledge ends cycle; device holds cycle until then
// - asynchronous inputs pass synchronisers first
// - synchronous mode skips synchroniser, cycle in three clocks
// - fast termination region completes in two clocks, no ack
// - inputs captured at one clock edge each
// - captured level always resolved clean before use; synchronous and fast modes use the single capture stage directly
// - protocol identical whoever masters the bus
// - asynchronous and synchronous styles serve 8 and 16 bit ports, fast style 16 bit only
// - size outputs show bytes still to transfer
// - address strobe half a clock after cycle start; the design asserts it one clock after, on the next rising edge
`timescale 1ns/1ps
`include "ebt_cfg.svh"
module ebt_bus_master
   import ebt_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // core request
   input  wire logic        reqValid,
   output logic             reqReady,
   input  wire logic [31:0] reqAddr,
   input  wire logic [1:0]  reqOp,
   input  wire logic        reqWrite,
   input  wire logic        reqLocked,
   input  wire logic        reqLast,
   input  wire logic [3:0]  reqSpace,
   input  wire logic [31:0] reqWrData,
   input  wire logic [1:0]  reqMode,
   // core answer
   output logic             rspValid,
   output logic             rspFault,
   output logic             rspMisaligned,
   output logic      [31:0] rspRdData,
   // arbitration
   input  wire logic        extMasterOwns,
   // bus pins
   output logic      [31:0] addrOut,
   output logic             addrOe,
   output logic      [3:0]  space_code,
   output logic             xfer_size_hi,
   output logic             xfer_size_lo,
   output logic             readNotWrite,
   output logic             addr_strobe_n,
   output logic             data_strobe_n,
   output logic             locked_rmw_cycle_n,
   output logic             ctrlOe,
   output logic      [15:0] dataOut,
   output logic             dataOe,
   input  wire logic [15:0] dataIn,
   input  wire logic        size_ack_hi_n,
   input  wire logic        size_ack_lo_n,
   input  wire logic        bus_fault_in_n
);
   typedef struct packed {
      ebt_state_t  state;
      logic [31:0] addr;
      logic [2:0]  left;
      logic [1:0]  clk;
      logic        write;
      logic        locked;
      logic [1:0]  mode;
      logic [3:0]  space;
      logic [31:0] wdata;
      logic        strobe;
      logic        dstrobe;
      logic        rmw;
      logic        fault;
      logic        mis;
      logic        rsp;
   } ebt_st_t;

   ebt_st_t stReg;
   ebt_st_t stNext;

   ebt_in_if inBus ();

   logic [31:0] laneWord;
   logic        laneWr;
   logic        laneTwo;
   logic        laneClr;
   logic [1:0]  laneIdx;
   logic        ackSeen;
   logic        port8;
   logic        twoBytes;
   logic [15:0] laneData;
   logic        termLive;

   ////////////////////////////////////////////////////////////////
   // input capture, synchroniser stages bypassed in synchronous and fast modes
   ebt_in_sampler #(.DEPTH(`EBT_SYNC_DEPTH)) uSampler (
      .core_clk    (core_clk),
      .rst         (rst),
      .syncBypass  (stReg.mode != EBT_MODE_ASYNC),
      .sizeAckHiN  (size_ack_hi_n),
      .sizeAckLoN  (size_ack_lo_n),
      .busFaultInN (bus_fault_in_n),
      .dataIn      (dataIn),
      .res         (inBus.sampler)
   );

   ebt_byte_lane uLane (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (laneClr),
      .wrEn     (laneWr),
      .wrIdx    (laneIdx),
      .wrTwo    (laneTwo),
      .wrData   (laneData),
      .rdWord   (laneWord)
   );

   ////////////////////////////////////////////////////////////////
   // acknowledge decode, port width from the pair
   // the pair decodes alike in every cycle style
   assign ackSeen = !(inBus.ackHiN && inBus.ackLoN);
   assign port8   = {inBus.ackHiN, inBus.ackLoN} == `EBT_ACK_PORT8;
   // two bytes only from an even address, on a wide port or in fast mode
   assign twoBytes = !stReg.addr[0] && (stReg.left >= 3'd2)
                     && (stReg.mode == EBT_MODE_FAST || !port8);
   // an odd byte on a wide port rides the low lane
   assign laneData = (stReg.addr[0] && !port8)
                     ? {inBus.rdData[7:0], inBus.rdData[15:8]} : inBus.rdData;
   // operand byte index, so the result ends up right-justified
   assign laneIdx = 2'(3'd4 - stReg.left);
   // synchroniser still holds the previous cycle's answer
   assign termLive = stReg.mode != EBT_MODE_ASYNC
                     || stReg.clk >= 2'(`EBT_SYNC_DEPTH);

   // bus engine next state
   always_comb begin
      stNext      = stReg;
      stNext.rsp  = 1'b0;
      laneClr     = 1'b0;
      laneWr      = 1'b0;
      laneTwo     = 1'b0;
      case (stReg.state)
         EBT_IDLE: begin
            if (reqValid && !extMasterOwns) begin
               laneClr      = 1'b1;
               stNext.addr  = reqAddr;
               stNext.write = reqWrite;
               stNext.space = reqSpace;
               stNext.wdata = reqWrData;
               stNext.mode  = reqMode;
               stNext.left  = (reqOp == EBT_OP_LONG) ? 3'd4 :
                              (reqOp == EBT_OP_WORD) ? 3'd2 : 3'd1;
               stNext.clk   = 2'd0;
               stNext.fault = 1'b0;
               // refuse misaligned word and long operands
               if (reqAddr[0] && reqOp != EBT_OP_BYTE) begin
                  stNext.mis = 1'b1;
                  stNext.rsp = 1'b1;
               end else begin
                  stNext.mis   = 1'b0;
                  stNext.state = EBT_ADDR;
                  stNext.rmw   = reqLocked;
               end
            end
         end
         EBT_ADDR: begin
            // strobe on the clock after the cycle begins
            stNext.strobe  = 1'b1;
            stNext.dstrobe = !stReg.write;
            stNext.clk     = 2'd1;
            stNext.state   = EBT_WAIT;
         end
         EBT_WAIT: begin
            stNext.dstrobe = 1'b1;
            // clock count saturates so a long wait never wraps it
            if (stReg.clk != 2'd3) begin
               stNext.clk = stReg.clk + 2'd1;
            end
            // fast region ends after two clocks regardless
            if (stReg.mode == EBT_MODE_FAST) begin
               if (stReg.clk == 2'(`EBT_FAST_CLKS - 1)) begin
                  stNext.state = EBT_DONE;
               end
            // hold the cycle open until termination
            end else if (termLive && !inBus.faultN) begin
               stNext.fault = 1'b1;
               stNext.state = EBT_ERROR;
            end else if (termLive && ackSeen) begin
               stNext.state = EBT_DONE;
            end
         end
         EBT_DONE: begin
            stNext.strobe  = 1'b0;
            stNext.dstrobe = 1'b0;
            laneWr  = !stReg.write;
            laneTwo = twoBytes;
            // narrow port splits into further cycles
            // next cycle at the next higher byte address
            if (twoBytes) begin
               stNext.left = stReg.left - 3'd2;
               stNext.addr = stReg.addr + 32'h0000_0002;
            end else begin
               stNext.left = stReg.left - 3'd1;
               stNext.addr = stReg.addr + 32'h0000_0001;
            end
            stNext.clk = 2'd0;
            if (stNext.left == 3'd0) begin
               stNext.rsp   = 1'b1;
               stNext.state = EBT_IDLE;
               stNext.rmw   = stReg.rmw && !reqLast;
            end else begin
               stNext.state = EBT_ADDR;
            end
         end
         EBT_ERROR: begin
            stNext.strobe  = 1'b0;
            stNext.dstrobe = 1'b0;
            stNext.rmw     = 1'b0;
            stNext.rsp     = 1'b1;
            stNext.state   = EBT_IDLE;
         end
         default: stNext.state = EBT_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stReg <= '{state: EBT_IDLE, addr: 32'h0000_0000, left: 3'd0,
                    clk: 2'd0, write: 1'b0, locked: 1'b0, mode: 2'd0,
                    space: 4'h0, wdata: 32'h0000_0000, strobe: 1'b0,
                    dstrobe: 1'b0, rmw: 1'b0, fault: 1'b0, mis: 1'b0,
                    rsp: 1'b0};
      end else begin
         stReg <= stNext;
      end
   end

   ////////////////////////////////////////////////////////////////
   // core handshake and answer
   assign reqReady      = stReg.state == EBT_IDLE && !extMasterOwns;
   assign rspValid      = stReg.rsp;
   assign rspFault      = stReg.fault;
   assign rspMisaligned = stReg.mis;
   assign rspRdData     = laneWord;

   assign {xfer_size_hi, xfer_size_lo} = ebt_size_code(stReg.left);
   assign addrOut       = stReg.addr;
   assign space_code    = stReg.space;
   assign readNotWrite  = !stReg.write;
   assign addr_strobe_n = !stReg.strobe;
   assign data_strobe_n = !stReg.dstrobe;
   assign locked_rmw_cycle_n = !stReg.rmw;
   // write data: lane chosen by the count of bytes still to move
   always_comb begin
      case (2'(stReg.left))
         2'd1:    dataOut = {2{stReg.wdata[7:0]}};
         2'd2:    dataOut = stReg.wdata[15:0];
         2'd3:    dataOut = {2{stReg.wdata[23:16]}};
         default: dataOut = stReg.wdata[31:16];
      endcase
   end
   // release bus outputs to an external master
   // the same pins serve either owner
   assign addrOe = !extMasterOwns;
   assign ctrlOe = !extMasterOwns;
   assign dataOe = !extMasterOwns && stReg.write && stReg.strobe;

   ////////////////////////////////////////////////////////////////
   // odd address cycle moves one byte
   odd_addr_single_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (stReg.state == EBT_DONE && stReg.addr[0] && stNext.state == EBT_ADDR)
      |=> stReg.addr == $past(stReg.addr) + 32'h0000_0001)
      else $error("two bytes from odd address");
   // fast cycle strobe stands two clocks
   fast_two_clk_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (stReg.state == EBT_ADDR && stReg.mode == EBT_MODE_FAST)
      |=> (stReg.state == EBT_WAIT) ##1 (stReg.state == EBT_DONE))
      else $error("fast cycle length wrong");
   hold_open_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (stReg.state == EBT_WAIT && stReg.mode != EBT_MODE_FAST
       && !ackSeen && inBus.faultN) |=> stReg.state == EBT_WAIT)
      else $error("cycle closed without ack");
   strobe_after_addr_a: assert property (
      @(posedge core_clk) disable iff (rst)
      $rose(stReg.strobe) |-> $past(stReg.state) == EBT_ADDR)
      else $error("strobe without address phase");
   // size shows the long code while strobed with four bytes remaining
   size_code_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (stReg.strobe && stReg.left == 3'd4) |->
      {xfer_size_hi, xfer_size_lo} == `EBT_SIZE_LONG)
      else $error("size code wrong");
   // split cycles move to higher addresses
   ascend_addr_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (stReg.state == EBT_DONE && stNext.state == EBT_ADDR) |=>
      stReg.addr > $past(stReg.addr))
      else $error("split not ascending");
   release_bus_a: assert property (
      @(posedge core_clk) disable iff (rst)
      extMasterOwns |-> !addrOe && !ctrlOe && !dataOe)
      else $error("bus driven under external master");
   // narrow port word read takes two cycles
   narrow_split_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (stReg.state == EBT_DONE && port8 && stReg.left == 3'd2
       && stReg.mode != EBT_MODE_FAST) |=> stReg.state == EBT_ADDR)
      else $error("narrow word not split");
endmodule : ebt_bus_master

/* File: dv/ebt_slave_model.sv */
// ebt_slave_model.sv: memory or peripheral answering the bus engine
// assumes: strobes from ebt_bus_master; acks pulled up when idle, data toggles
`timescale 1ns/1ps
`include "ebt_cfg.svh"
module ebt_slave_model
   import ebt_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // behaviour knobs
   input  wire logic        port8,
   input  wire logic        mute,
   input  wire logic [2:0]  waitCycles,
   // bus side
   input  wire logic [31:0] addrOut,
   input  wire logic        addr_strobe_n,
   input  wire logic        readNotWrite,
   output logic      [15:0] dataIn,
   output logic             size_ack_hi_n,
   output logic             size_ack_lo_n
);
   logic [2:0]  waitReg;
   logic        noiseReg;
   logic        ackOn;
   logic        readyOn;
   logic [31:0] evenA;

   // contents of one byte place
   function automatic logic [7:0] byteAt(input logic [31:0] a);
      byteAt = a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction : byteAt

   // cycles spent with the strobe low, and a toggling idle pattern
   always_ff @(posedge core_clk) begin
      noiseReg <= rst ? 1'b0 : ~noiseReg;
      if (rst || addr_strobe_n) waitReg <= 3'h0;
      else if (waitReg != 3'h7) waitReg <= waitReg + 3'h1;
   end

   // slave ends cycle
   // data stands once the wait is over, also when acks come from inside
   assign readyOn = !addr_strobe_n && (waitReg >= waitCycles);
   assign ackOn = readyOn && !mute;
   assign evenA = {addrOut[31:1], 1'b0};
   // port size answer, active low, released high otherwise
   assign {size_ack_hi_n, size_ack_lo_n} = !ackOn ? 2'h3 :
      (port8 ? `EBT_ACK_PORT8 : `EBT_ACK_PORT16);
   // 8-bit port drives the upper lane only; released lanes toggle
   assign dataIn = !(readyOn && readNotWrite) ? {16{noiseReg}} :
      port8 ? {byteAt(addrOut), {8{noiseReg}}} :
      {byteAt(evenA), byteAt(evenA | 32'h1)};
endmodule : ebt_slave_model

/* File: dv/test_ebt_bus_master.sv */
// test_ebt_bus_master.sv: self-checking bench of the bus engine
// assumes: one 100 MHz clock, inputs driven at the falling edge
`timescale 1ns/1ps
`define EBT_CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin \
   miscompares++; $display("mismatch %0t %s", $time, msg); end end
module test_ebt_bus_master;
   import ebt_pkg::*;
   logic core_clk = 0, rst = 1, reqValid = 0, reqWrite = 0, reqLocked = 0;
   logic reqLast = 1, extMasterOwns = 0, port8 = 0, mute = 0, faultOn = 0;
   logic [31:0] reqAddr = 0, reqWrData = 0, rspRdData, addrOut, curA;
   logic [1:0]  reqOp = 0, reqMode = 0;
   logic [3:0]  reqSpace = 0, space_code;
   logic [2:0]  waitCycles = 0;
   logic [15:0] dataIn, dataOut;
   logic reqReady, rspValid, rspFault, rspMisaligned, addrOe, ctrlOe, dataOe;
   logic xfer_size_hi, xfer_size_lo, readNotWrite, addr_strobe_n;
   logic data_strobe_n, locked_rmw_cycle_n, ackHiN, ackLoN, asPrev = 1;
   int miscompares = 0, n_checks = 0, cycles = 0, sent, nCyc, curN;
   logic [31:0] seed = 32'h0557_5d97;

   always #5 core_clk = ~core_clk;

   ebt_bus_master u_ebt_bus_master (.core_clk(core_clk), .rst(rst),
      .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr),
      .reqOp(reqOp), .reqWrite(reqWrite), .reqLocked(reqLocked),
      .reqLast(reqLast), .reqSpace(reqSpace), .reqWrData(reqWrData),
      .reqMode(reqMode), .rspValid(rspValid), .rspFault(rspFault),
      .rspMisaligned(rspMisaligned), .rspRdData(rspRdData),
      .extMasterOwns(extMasterOwns), .addrOut(addrOut), .addrOe(addrOe),
      .space_code(space_code), .xfer_size_hi(xfer_size_hi),
      .xfer_size_lo(xfer_size_lo), .readNotWrite(readNotWrite),
      .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
      .locked_rmw_cycle_n(locked_rmw_cycle_n), .ctrlOe(ctrlOe),
      .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
      .size_ack_hi_n(ackHiN), .size_ack_lo_n(ackLoN),
      .bus_fault_in_n(!(faultOn && !addr_strobe_n)));

   ebt_slave_model u_ebt_slave_model (.core_clk(core_clk), .rst(rst),
      .port8(port8), .mute(mute), .waitCycles(waitCycles),
      .addrOut(addrOut), .addr_strobe_n(addr_strobe_n),
      .readNotWrite(readNotWrite), .dataIn(dataIn),
      .size_ack_hi_n(ackHiN), .size_ack_lo_n(ackLoN));

   // random source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // expected contents of one byte place
   function automatic logic [7:0] byteAt(input logic [31:0] a);
      byteAt = a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction : byteAt

   // bytes still to move as a size code
   function automatic logic [1:0] sizeOf(input int n);
      sizeOf = (n == 1) ? 2'h1 : (n == 2) ? 2'h2 : (n == 3) ? 2'h3 : 2'h0;
   endfunction : sizeOf

   // verdict and end of run
   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   // cut a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // bus cycle monitor: checks each cycle at its strobe assertion
   always @(negedge core_clk) begin
      if (asPrev && !addr_strobe_n) begin
         `EBT_CHK(addrOut, curA + sent, "cycle address")
         `EBT_CHK({xfer_size_hi, xfer_size_lo}, sizeOf(curN - sent),
            "size code")
         `EBT_CHK(readNotWrite, !reqWrite, "direction")
         `EBT_CHK(space_code, reqSpace, "space code")
         `EBT_CHK(locked_rmw_cycle_n, !reqLocked, "locked flag")
         if (reqWrite) begin
            `EBT_CHK(dataOut[15:8], 8'(reqWrData >> (8 * (curN - 1 - sent))),
               "write data")
         end
         `EBT_CHK(dataOe, reqWrite, "data drive")
         // odd address or 8-bit port moves one byte
         sent += (port8 || addrOut[0]) ? 1 : 2;
         nCyc++;
      end
      asPrev = addr_strobe_n;
   end

   // one operand from request to answer, then compare
   task automatic doOp(input logic [31:0] a, input logic [1:0] op,
                       input logic w, input logic [1:0] md, input logic p8,
                       input logic [2:0] wt, input logic f);
      logic [31:0] exp;
      logic        mis;
      int          i;
      curA = a;
      curN = (op == 2'h0) ? 1 : (op == 2'h1) ? 2 : 4;
      mis = (op != 2'h0) && a[0];
      sent = 0;
      nCyc = 0;
      exp = 32'h0000_0000;
      for (i = 0; i < curN; i++) exp = {exp[23:0], byteAt(a + i)};
      port8 = p8;
      mute = f || (md == 2'h2);
      waitCycles = wt;
      faultOn = f;
      reqAddr = a;
      reqOp = op;
      reqWrite = w;
      reqMode = md;
      reqLocked = rnd() % 2;
      reqSpace = rnd() % 16;
      reqWrData = rnd();
      reqValid = 1;
      i = 0;
      // ready is looked at off the edge; the take is the next rising edge
      while (reqReady !== 1'b1 && i < 50) begin
         @(negedge core_clk);
         i++;
      end
      @(negedge core_clk);
      reqValid = 0;
      i = 0;
      while (rspValid !== 1'b1 && i < 300) begin
         @(negedge core_clk);
         i++;
      end
      `EBT_CHK(rspValid, 1'b1, "no answer")
      // misaligned word or long is refused without a bus cycle
      `EBT_CHK(rspMisaligned, mis, "misalign flag")
      `EBT_CHK(rspFault, f && !mis, "fault flag")
      if (!f) begin
         // count of bus cycles per operand
         `EBT_CHK(nCyc, mis ? 0 : (p8 ? curN : (curN + 1) / 2),
            "cycle count")
      end
      if (!mis && !f && !w) begin
         // assembled read data, latched at the end of each bus cycle
         `EBT_CHK(rspRdData, exp, "read data")
      end
      faultOn = 0;
      // let an edge pass before the next request is raised
      @(negedge core_clk);
   endtask : doOp

   // main sequence
   initial begin
      logic [1:0] md;
      repeat (20) @(negedge core_clk);
      rst = 0;
      // corner cases: odd byte, misaligned word and long, narrow-port long with wait states
      doOp(32'h0000_1001, 2'h0, 1'b0, 2'h1, 1'b0, 3'h0, 1'b0);
      doOp(32'h0000_2003, 2'h1, 1'b0, 2'h1, 1'b0, 3'h0, 1'b0);
      doOp(32'h0000_2005, 2'h2, 1'b0, 2'h0, 1'b1, 3'h0, 1'b0);
      doOp(32'h0000_3002, 2'h2, 1'b0, 2'h0, 1'b1, 3'h3, 1'b0);
      // fast region completes with the slave silent; then a word faulted in asynchronous style
      doOp(32'h0000_4000, 2'h2, 1'b0, 2'h2, 1'b0, 3'h0, 1'b0);
      doOp(32'h0000_5000, 2'h1, 1'b0, 2'h0, 1'b0, 3'h0, 1'b1);
      // outputs released while another master owns the bus
      extMasterOwns = 1;
      @(negedge core_clk);
      `EBT_CHK({addrOe, ctrlOe, dataOe, reqReady}, 4'h0, "bus release")
      extMasterOwns = 0;
      @(negedge core_clk);
      // random operands over all styles and port widths
      repeat (60) begin
         md = rnd() % 3;
         // a fast region slave answers with no wait states
         doOp(rnd(), rnd() % 3, rnd() % 2, md, (md != 2'h2) && rnd() % 2,
            (md == 2'h2) ? 3'h0 : 3'(rnd() % 4), 1'b0);
      end
      report_and_stop();
   end
endmodule : test_ebt_bus_master
